// ---- src/ldp_pkg.sv ----
package ldp_pkg;
    localparam int          NUM_CHANNELS    = 2;
    localparam int          CODE_W          = 10;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          DIV_CODE_W      = 3;
    localparam int          RATIO_W         = 8;
    localparam int          ACC_W           = 16;
    // master oscillator is synthesised from clk by a phase accumulator
    localparam int          CLK_FREQ_KHZ    = 20000;
    localparam int          OSC_FREQ_KHZ    = 10800;
    localparam logic [ACC_W-1:0] CLK_STEP   = ACC_W'(CLK_FREQ_KHZ);
    localparam logic [ACC_W-1:0] OSC_STEP   = ACC_W'(OSC_FREQ_KHZ);
    localparam logic [CODE_W-1:0] DUTY_LOAD_COUNT = 10'h3FE;

    localparam logic [ADDR_W-1:0] ADDR_SYS_CFG1  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_WORD_ONE   = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_WORD_THREE   = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_HI0  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_LO0  = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_CLK_DIV   = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_IADJ_HI0  = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IADJ_LO0  = 8'h11;
    localparam logic [ADDR_W-1:0] CH_ADDR_STRIDE = 8'h02;

    localparam int          CFG_INTSEL_LSB  = 0;
    localparam int          CFG_ENABLE_LSB  = 2;
    localparam int          CFG_SLEEP_BIT   = 7;
    localparam int          ST3_PC_BIT      = 0;
    localparam int          ST3_ABL_BIT     = 1;
    localparam int          HI_BITS         = 2;

    localparam logic [DATA_W-1:0] SYS_CFG1_RST = 8'h00;
    localparam logic [DATA_W-1:0] CLK_DIV_RST  = 8'h04;
    localparam logic [DATA_W-1:0] RD_ZERO      = 8'h00;

    // only code 5 is fixed; the remaining ratios are a plain spread
    function automatic logic [RATIO_W-1:0] ldp_div_ratio(input logic [DIV_CODE_W-1:0] code);
        case (code)
            3'h0:    ldp_div_ratio = 8'h01;
            3'h1:    ldp_div_ratio = 8'h02;
            3'h2:    ldp_div_ratio = 8'h04;
            3'h3:    ldp_div_ratio = 8'h08;
            3'h4:    ldp_div_ratio = 8'h10;
            3'h5:    ldp_div_ratio = 8'h18;
            3'h6:    ldp_div_ratio = 8'h20;
            default: ldp_div_ratio = 8'h40;
        endcase
    endfunction : ldp_div_ratio
endpackage : ldp_pkg

// ---- src/ldp_tick_gen.sv ----
module ldp_tick_gen (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic [ldp_pkg::DIV_CODE_W-1:0] div_code,
    output logic                                dim_tick
);
    import ldp_pkg::*;

    logic [ACC_W-1:0]   acc_reg;
    logic [ACC_W-1:0]   acc_sum;
    logic               osc_tick;
    logic [RATIO_W-1:0] div_cnt_reg;
    logic [RATIO_W-1:0] ratio;
    logic               div_wrap;

    // average rate of osc_tick is OSC_FREQ out of CLK_FREQ cycles
    assign acc_sum  = acc_reg + OSC_STEP;
    assign osc_tick = (acc_sum >= CLK_STEP);
    assign ratio    = ldp_div_ratio(div_code);
    assign div_wrap = (div_cnt_reg >= ratio - 8'h01);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= osc_tick ? acc_sum - CLK_STEP : acc_sum;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= '0;
            dim_tick    <= 1'b0;
        end else begin
            dim_tick <= osc_tick && div_wrap;
            if (osc_tick) begin
                div_cnt_reg <= div_wrap ? '0 : div_cnt_reg + 8'h01;
            end
        end
    end
endmodule : ldp_tick_gen

// ---- src/ldp_dim_channel.sv ----
module ldp_dim_channel (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       dim_tick,
    input  wire logic [ldp_pkg::CODE_W-1:0] pending_duty,
    output logic                            dim_wave
);
    import ldp_pkg::*;

    logic [CODE_W-1:0] count_reg;
    logic [CODE_W-1:0] active_duty_reg;

    // counter free-runs 0..1023 and wraps by overflow
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (dim_tick) begin
            count_reg <= count_reg + 10'h001;
        end
    end

    // late load keeps the running period intact
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_duty_reg <= '0;
        end else if (dim_tick && count_reg == DUTY_LOAD_COUNT) begin
            active_duty_reg <= pending_duty;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dim_wave <= 1'b0;
        end else begin
            dim_wave <= (count_reg < active_duty_reg);
        end
    end
endmodule : ldp_dim_channel

// ---- src/ldp_dimming_top.sv ----
// Summary of operation
// - each channel has free-running 10-bit dimming counter
// - internal dimming drives channel only when selected
// - duty is 10 bits across high/low bytes
// - only low-byte write updates pending duty
// - pending duty loads into compare at 1022
// - tick is oscillator over 3-bit-coded ratio
// - master oscillator runs at nominal 10.8 MHz
// - divider code 5 selects ratio 24
// - divider register at 0x0C, resets to 0x04
// - switch enable is external dim AND waveform
// - loop overvoltage above 3.2 V sets flag
// - channel stops on enable clear or dim low
// - per-channel 10-bit analog current code held, applied
// - run only while both bias supplies good
// - power-cycle flag set at power-up, loss of both bias supplies
// - reading status three clears power-cycle flag
// - sleep disconnects analog bias; low sets flag
// - analog bias low flag clears leaving sleep
module ldp_dimming_top #(
    parameter int NCH = ldp_pkg::NUM_CHANNELS
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic [ldp_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ldp_pkg::DATA_W-1:0] reg_wdata,
    output logic      [ldp_pkg::DATA_W-1:0] reg_rdata,
    output logic                            reg_rvalid,
    input  wire logic [NCH-1:0]             external_dim_input,
    input  wire logic [NCH-1:0]             loop_over_threshold,
    input  wire logic                       digital_bias_supply_ok,
    input  wire logic                       analog_bias_supply_ok,
    output logic      [NCH-1:0]             switch_enable,
    output logic      [NCH*ldp_pkg::CODE_W-1:0] analog_current_code,
    output logic                            analog_bias_connect
);
    import ldp_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] target);
        hit = (addr == target);
    endfunction : hit

    function automatic logic [ADDR_W-1:0] ch_addr(input logic [ADDR_W-1:0] base,
                                                  input int              ch);
        ch_addr = base + ADDR_W'(ch) * CH_ADDR_STRIDE;
    endfunction : ch_addr

    logic [DATA_W-1:0]     sys_cfg1_reg;
    logic [DATA_W-1:0]     clk_div_reg;
    logic [HI_BITS-1:0]    duty_high_byte_reg [NCH];
    logic [DATA_W-1:0]     duty_low_byte_reg  [NCH];
    logic [CODE_W-1:0]     pending_duty_reg   [NCH];
    logic [HI_BITS-1:0]    iadj_high_reg      [NCH];
    logic [DATA_W-1:0]     iadj_low_reg       [NCH];
    logic [NCH-1:0]        loop_ov_flag_reg;
    logic [NCH-1:0]        loop_ov_flag_next;
    logic                  power_cycle_flag_reg;
    logic                  power_cycle_flag_next;
    logic                  analog_bias_low_flag_reg;
    logic                  analog_bias_low_flag_next;
    logic [DATA_W-1:0]     rd_mux;
    logic [NCH-1:0]        dim_wave;
    logic [NCH-1:0]        switch_enable_next;
    logic                  dim_tick;
    logic                  wr_cfg1;
    logic                  wr_div;
    logic                  rd_status_word_one;
    logic                  rd_status_word_three;
    logic                  sleep_mode;
    logic                  bias_ok;
    logic                  bias_lost;
    logic [NCH-1:0]        intsel;
    logic [NCH-1:0]        chan_enable;

    // register strobes
    assign wr_cfg1     = reg_wr && hit(reg_addr, ADDR_SYS_CFG1);
    assign wr_div      = reg_wr && hit(reg_addr, ADDR_CLK_DIV);
    assign rd_status_word_one  = reg_rd && hit(reg_addr, ADDR_STATUS_WORD_ONE);
    assign rd_status_word_three  = reg_rd && hit(reg_addr, ADDR_STATUS_WORD_THREE);

    // configuration fields
    assign sleep_mode  = sys_cfg1_reg[CFG_SLEEP_BIT];
    assign intsel      = sys_cfg1_reg[CFG_INTSEL_LSB +: NCH];
    assign chan_enable = sys_cfg1_reg[CFG_ENABLE_LSB +: NCH];

    // comparator hysteresis sits outside; these are plain levels here
    assign bias_ok     = digital_bias_supply_ok && analog_bias_supply_ok;
    assign bias_lost   = !digital_bias_supply_ok && !analog_bias_supply_ok;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_cfg1_reg <= SYS_CFG1_RST;
        end else if (wr_cfg1) begin
            sys_cfg1_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_div_reg <= CLK_DIV_RST;
        end else if (wr_div) begin
            clk_div_reg <= reg_wdata;
        end
    end

    ldp_tick_gen u_tick_gen (
        .clk      (clk),
        .rst      (rst),
        .div_code (clk_div_reg[DIV_CODE_W-1:0]),
        .dim_tick (dim_tick)
    );

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic wr_duty_hi;
            logic wr_duty_lo;
            logic wr_iadj_hi;
            logic wr_iadj_lo;
            logic gate_wave;

            assign wr_duty_hi = reg_wr && hit(reg_addr, ch_addr(ADDR_DUTY_HI0, c));
            assign wr_duty_lo = reg_wr && hit(reg_addr, ch_addr(ADDR_DUTY_LO0, c));
            assign wr_iadj_hi = reg_wr && hit(reg_addr, ch_addr(ADDR_IADJ_HI0, c));
            assign wr_iadj_lo = reg_wr && hit(reg_addr, ch_addr(ADDR_IADJ_LO0, c));
            // unselected channel follows the external dim level alone
            assign gate_wave  = intsel[c] ? dim_wave[c] : 1'b1;

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    duty_high_byte_reg[c] <= '0;
                end else if (wr_duty_hi) begin
                    duty_high_byte_reg[c] <= reg_wdata[HI_BITS-1:0];
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    duty_low_byte_reg[c] <= '0;
                end else if (wr_duty_lo) begin
                    duty_low_byte_reg[c] <= reg_wdata;
                end
            end

            // high byte alone never reaches the pending code
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pending_duty_reg[c] <= '0;
                end else if (wr_duty_lo) begin
                    pending_duty_reg[c] <= {duty_high_byte_reg[c], reg_wdata};
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    iadj_high_reg[c] <= '0;
                end else if (wr_iadj_hi) begin
                    iadj_high_reg[c] <= reg_wdata[HI_BITS-1:0];
                end
            end

            // current code applies on either byte write, no staging
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    iadj_low_reg[c] <= '0;
                end else if (wr_iadj_lo) begin
                    iadj_low_reg[c] <= reg_wdata;
                end
            end

            assign analog_current_code[c*CODE_W +: CODE_W] = {iadj_high_reg[c], iadj_low_reg[c]};

            ldp_dim_channel u_dim (
                .clk          (clk),
                .rst          (rst),
                .dim_tick     (dim_tick),
                .pending_duty (pending_duty_reg[c]),
                .dim_wave     (dim_wave[c])
            );

            // flag set wins over a read clear in the same cycle
            assign loop_ov_flag_next[c] = loop_over_threshold[c]
                                        || (loop_ov_flag_reg[c] && !rd_status_word_one);

            assign switch_enable_next[c] = chan_enable[c]
                                         && bias_ok && !sleep_mode
                                         && external_dim_input[c]
                                         && gate_wave;
        end
    endgenerate

    assign power_cycle_flag_next     = bias_lost || (power_cycle_flag_reg && !rd_status_word_three);
    assign analog_bias_low_flag_next = (sleep_mode && !analog_bias_supply_ok)
                                     || (analog_bias_low_flag_reg && sleep_mode);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loop_ov_flag_reg <= '0;
        end else begin
            loop_ov_flag_reg <= loop_ov_flag_next;
        end
    end

    // set at power-up so the host sees the bias history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_cycle_flag_reg <= 1'b1;
        end else begin
            power_cycle_flag_reg <= power_cycle_flag_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_bias_low_flag_reg <= 1'b0;
        end else begin
            analog_bias_low_flag_reg <= analog_bias_low_flag_next;
        end
    end

    // enable gated by enable bit, bias, sleep, external dim and waveform, not by power-cycle flag; host ordering vs that flag is software's job
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            switch_enable <= '0;
        end else begin
            switch_enable <= switch_enable_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_bias_connect <= 1'b1;
        end else begin
            analog_bias_connect <= !sleep_mode;
        end
    end

    always_comb begin
        rd_mux = RD_ZERO;
        if (hit(reg_addr, ADDR_SYS_CFG1)) begin
            rd_mux = sys_cfg1_reg;
        end
        if (hit(reg_addr, ADDR_CLK_DIV)) begin
            rd_mux = clk_div_reg;
        end
        if (hit(reg_addr, ADDR_STATUS_WORD_ONE)) begin
            rd_mux[NCH-1:0] = loop_ov_flag_reg;
        end
        if (hit(reg_addr, ADDR_STATUS_WORD_THREE)) begin
            rd_mux[ST3_PC_BIT]  = power_cycle_flag_reg;
            rd_mux[ST3_ABL_BIT] = analog_bias_low_flag_reg;
        end
        for (int i = 0; i < NCH; i++) begin
            if (hit(reg_addr, ch_addr(ADDR_DUTY_HI0, i))) begin
                rd_mux[HI_BITS-1:0] = duty_high_byte_reg[i];
            end
            if (hit(reg_addr, ch_addr(ADDR_DUTY_LO0, i))) begin
                rd_mux = duty_low_byte_reg[i];
            end
        end

        for (int i = 0; i < NCH; i++) begin
            if (hit(reg_addr, ch_addr(ADDR_IADJ_HI0, i))) begin
                rd_mux[HI_BITS-1:0] = iadj_high_reg[i];
            end
            if (hit(reg_addr, ch_addr(ADDR_IADJ_LO0, i))) begin
                rd_mux = iadj_low_reg[i];
            end
        end
    end

    // read data held until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= RD_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // fixed one-cycle answer, no wait states
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end
endmodule : ldp_dimming_top

// ---- testbench/ldp_host_model.sv ----
module ldp_host_model import ldp_pkg::*; (
    input  wire logic              clk,
    output logic                   reg_wr,
    output logic                   reg_rd,
    output logic [ADDR_W-1:0]      reg_addr,
    output logic [DATA_W-1:0]      reg_wdata,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = reg_rvalid;
        d = reg_rdata;
    endtask : rd
    task automatic set_duty(input int ch, input logic [9:0] code);
        wr(8'(ADDR_DUTY_HI0 + ch * 2), {6'h00, code[9:8]});
        wr(8'(ADDR_DUTY_LO0 + ch * 2), code[7:0]);
    endtask : set_duty
endmodule : ldp_host_model

// ---- testbench/ldp_dimming_top_sva.sv ----
module ldp_dimming_top_sva import ldp_pkg::*; #(
    parameter int NCH = 2
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [ADDR_W-1:0]     reg_addr,
    input wire logic [DATA_W-1:0]     reg_wdata,
    input wire logic [DATA_W-1:0]     reg_rdata,
    input wire logic                  reg_rvalid,
    input wire logic [NCH-1:0]        external_dim_input,
    input wire logic [NCH-1:0]        loop_over_threshold,
    input wire logic                  digital_bias_supply_ok,
    input wire logic                  analog_bias_supply_ok,
    input wire logic [NCH-1:0]        switch_enable,
    input wire logic [NCH*CODE_W-1:0] analog_current_code,
    input wire logic                  analog_bias_connect
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    rvalid_follows_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered one cycle later");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid without a read");
    unmapped_read_a: assert property ((reg_rd && reg_addr == 8'hFF) |=> reg_rdata == RD_ZERO)
        else $error("unmapped read not zero");
    ext_dim_gate_a: assert property ((switch_enable & ~$past(external_dim_input)) == '0)
        else $error("switching while external dim low");
    bias_gate_a: assert property (!(digital_bias_supply_ok && analog_bias_supply_ok) |=> switch_enable == '0)
        else $error("switching without bias");
    enable_clear_a: assert property ((reg_wr && reg_addr == ADDR_SYS_CFG1 && !reg_wdata[CFG_ENABLE_LSB])
        |-> ##2 !switch_enable[0]) else $error("channel runs after enable cleared");
    sleep_cut_a: assert property ((reg_wr && reg_addr == ADDR_SYS_CFG1 && reg_wdata[CFG_SLEEP_BIT])
        |-> ##[1:2] !analog_bias_connect) else $error("bias stays connected in sleep");
    current_code_a: assert property ((reg_wr && reg_addr == ADDR_IADJ_LO0)
        |=> analog_current_code[7:0] == $past(reg_wdata)) else $error("current code not applied");
endmodule : ldp_dimming_top_sva

// ---- testbench/ldp_dimming_top_tb_top.sv ----
module ldp_dimming_top_tb_top import ldp_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, reg_wr, reg_rd, reg_rvalid, d_ok, a_ok, bias_conn;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [1:0]  ext_dim, loop_ov, sw_en;
    logic [19:0] cur_code;
    int          error_cnt, n_compared;
    int          model_cur[2];
    int          duty_q[$];
    ldp_dimming_top #(.NCH(2)) i_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .external_dim_input(ext_dim), .loop_over_threshold(loop_ov), .digital_bias_supply_ok(d_ok),
        .analog_bias_supply_ok(a_ok), .switch_enable(sw_en), .analog_current_code(cur_code),
        .analog_bias_connect(bias_conn));
    ldp_host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        i_host.rd(a, d, v);
        check(32'(v), 32'h1);
        check(32'(d), 32'(exp));
    endtask : rdchk
    task automatic wait_lvl(input int ch, input logic v);
        int k;
        k = 0;
        while (sw_en[ch] !== v && k < 5000) begin
            @(negedge clk);
            k++;
        end
        if (k == 5000) check(32'h0, 32'h1);
    endtask : wait_lvl
    // high time of the second full period, so the new code is surely active
    task automatic chk_duty(input int ch, input int d);
        int n;
        int e;
        n = 0;
        e = d * OSC_FREQ_KHZ == 0 ? 0 : d * CLK_FREQ_KHZ / OSC_FREQ_KHZ;
        repeat (2) begin
            wait_lvl(ch, 1'b0);
            wait_lvl(ch, 1'b1);
        end
        while (sw_en[ch] === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check(32'(n >= e - 3 && n <= e + 3), 32'h1);
    endtask : chk_duty
    initial begin
        #(50ns * 60000);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        int v;
        int lows;
        void'($urandom(84875));
        rst = 1'b1;
        ext_dim = 2'b11;
        loop_ov = 2'b00;
        d_ok = 1'b1;
        a_ok = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdchk(ADDR_CLK_DIV, CLK_DIV_RST);
        rdchk(ADDR_STATUS_WORD_THREE, 8'h01);
        rdchk(ADDR_STATUS_WORD_THREE, 8'h00);
        rdchk(8'hFF, RD_ZERO);
        for (int c = 7; c >= 0; c--) begin
            i_host.wr(ADDR_CLK_DIV, 8'(c));
            rdchk(ADDR_CLK_DIV, 8'(c));
        end
        for (int ch = 0; ch < 2; ch++) begin
            model_cur[ch] = $urandom % 1024;
            i_host.wr(8'(ADDR_IADJ_HI0 + ch * 2), 8'(model_cur[ch] >> 8));
            i_host.wr(8'(ADDR_IADJ_LO0 + ch * 2), 8'(model_cur[ch]));
            @(negedge clk);
            check(32'(cur_code[ch*10 +: 10]), 32'(model_cur[ch]));
        end
        repeat (2) duty_q.push_back(64 + $urandom % 800);
        i_host.set_duty(0, 10'(duty_q[0]));
        i_host.wr(ADDR_SYS_CFG1, 8'h0F);
        @(posedge clk);
        ext_dim <= 2'b01;
        chk_duty(0, duty_q[0]);
        check(32'(sw_en[1]), 32'h0);
        i_host.wr(ADDR_DUTY_HI0, 8'(~(duty_q[0] >> 8)) & 8'h03);
        chk_duty(0, duty_q[0]);
        i_host.set_duty(0, 10'(duty_q[1]));
        chk_duty(0, duty_q[1]);
        i_host.wr(ADDR_SYS_CFG1, 8'h0E);
        repeat (2) @(negedge clk);
        lows = 0;
        repeat (2200) begin
            @(negedge clk);
            if (sw_en[0] !== 1'b1) lows++;
        end
        check(32'(lows), 32'h0);
        @(posedge clk);
        loop_ov <= 2'b10;
        @(posedge clk);
        loop_ov <= 2'b00;
        rdchk(ADDR_STATUS_WORD_ONE, 8'h02);
        rdchk(ADDR_STATUS_WORD_ONE, 8'h00);
        @(posedge clk);
        ext_dim <= 2'b00;
        repeat (3) @(negedge clk);
        check(32'(sw_en), 32'h0);
        @(posedge clk);
        a_ok <= 1'b0;
        i_host.wr(ADDR_SYS_CFG1, 8'h80);
        repeat (3) @(negedge clk);
        check(32'(bias_conn), 32'h0);
        rdchk(ADDR_STATUS_WORD_THREE, 8'h02);
        i_host.wr(ADDR_SYS_CFG1, 8'h00);
        a_ok <= 1'b1;
        repeat (3) @(negedge clk);
        rdchk(ADDR_STATUS_WORD_THREE, 8'h00);
        @(posedge clk);
        ext_dim <= 2'b11;
        i_host.wr(ADDR_SYS_CFG1, 8'h04);
        repeat (3) @(negedge clk);
        check(32'(sw_en), 32'h1);
        @(posedge clk);
        d_ok <= 1'b0;
        a_ok <= 1'b0;
        repeat (3) @(negedge clk);
        check(32'(sw_en), 32'h0);
        @(posedge clk);
        d_ok <= 1'b1;
        a_ok <= 1'b1;
        rdchk(ADDR_STATUS_WORD_THREE, 8'h01);
        report_and_stop();
    end
endmodule : ldp_dimming_top_tb_top
bind ldp_dimming_top ldp_dimming_top_sva #(.NCH(NCH)) i_sva (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .external_dim_input(external_dim_input),
    .loop_over_threshold(loop_over_threshold), .digital_bias_supply_ok(digital_bias_supply_ok),
    .analog_bias_supply_ok(analog_bias_supply_ok), .switch_enable(switch_enable),
    .analog_current_code(analog_current_code), .analog_bias_connect(analog_bias_connect));
